// >>> verif/sfmb_biu_properties.sv
// Concurrent checks on the ports of the flash bus-interface block.
// Assumes one clock domain and a serial half period of four clocks.
`timescale 1ns/1ps
module sfmb_biu_properties #(
  parameter SCK_HALF = 4
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire flash_cs_n,
  input wire flash_sck,
  input wire flash_mosi,
  input wire mem_rd,
  input wire mem_wr,
  input wire core_soft_reset
);
  reg [7:0] op;
  reg [2:0] bits;
  reg sck_d;
  // Shadow of the opcode register and a count of serial clock rises within a frame.
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      op <= 8'h00;
      bits <= 3'h0;
      sck_d <= 1'b0;
    end
    else
    begin
      sck_d <= flash_sck;
      if (reg_wr && reg_addr == 8'hf0)
        op <= reg_wdata;
      if (flash_cs_n)
        bits <= 3'h0;
      else if (flash_sck && !sck_d)
        bits <= bits + 3'h1;
    end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_idle_sck_low: assert property (flash_cs_n |-> !flash_sck)
    else $error("serial clock high while deselected");
  a_sck_high_len: assert property ($rose(flash_sck) |-> flash_sck[*4] ##1 !flash_sck)
    else $error("serial clock high phase has wrong length");
  a_mosi_hold_high: assert property (flash_sck && $past(flash_sck) |-> $stable(flash_mosi))
    else $error("data out changed while serial clock high");
  a_whole_bytes: assert property ($rose(flash_cs_n) |-> bits == 3'h0)
    else $error("frame ended inside a byte");
  a_opcode_read: assert property (reg_addr == 8'hf0 && !reg_wr |=> reg_rdata == op)
    else $error("opcode register reads wrong value");
  a_unmapped_zero: assert property (reg_addr < 8'he0 |=> reg_rdata == 8'h00)
    else $error("unmapped offset reads nonzero");
  a_soft_reset_pulse: assert property (reg_wr && reg_addr == 8'hfe && reg_wdata[6] |=> core_soft_reset ##1
    (!core_soft_reset || $past(reg_wr && reg_addr == 8'hfe && reg_wdata[6])))
    else $error("core reset pulse missing or too long");
  a_soft_reset_cause: assert property (core_soft_reset |-> $past(reg_wr && reg_addr == 8'hfe && reg_wdata[6]))
    else $error("core reset pulse without a write");
  a_mem_pulse_one: assert property (mem_wr || mem_rd |=> !mem_wr && !mem_rd)
    else $error("memory strobe longer than one cycle");
  c_frame_end: cover property ($rose(flash_cs_n));
  c_mem_write: cover property (mem_wr);
  c_mem_read: cover property (mem_rd);
  c_core_reset: cover property (core_soft_reset);
endmodule
bind sfmb_biu sfmb_biu_properties #(.SCK_HALF(SCK_HALF)) sfmb_biu_properties_i (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_mosi(flash_mosi),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .core_soft_reset(core_soft_reset));

// >>> verif/sfmb_biu_test.sv
// Self-checking bench for the flash bus-interface block.
// Assumes the flash model in sfmb_flash and a memory that answers one cycle after a read strobe.
`timescale 1ns/1ps
module sfmb_biu_test;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_from_host = 1'b0;
  reg [7:0] mem_rdata = 8'h00;
  reg strap_pin = 1'b0;
  reg overlay_enable = 1'b0;
  reg osd = 1'b0;
  reg slow = 1'b0;
  wire [7:0] reg_rdata, mem_wdata;
  wire cs_n, sck, mosi, miso, mem_rd, mem_wr;
  wire [15:0] mem_addr;
  wire core_enable, core_soft_reset, core_stall, core_wait, cache_enable, tsrc, tinv;
  wire [2:0] seg;
  wire [1:0] page;
  wire [15:0] fpos = sfmb_flash_i.pos;
  wire [15:0] frames = sfmb_flash_i.frames;
  reg [7:0] mem [0:65535];
  reg [7:0] mb [0:15];
  reg [7:0] ex [0:7];
  reg [7:0] v, rv, op, d;
  reg [23:0] ad;
  reg [2:0] wl;
  reg [1:0] rl;
  reg [15:0] m, nr, n, k, t, f0, da;
  integer i;
  integer seed = 32'hbcc3;
  integer err_count = 0;
  integer check_count = 0;
  integer cyc = 0;
  always #5 clk = ~clk;
  sfmb_biu sfmb_biu_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_from_host(reg_from_host), .reg_rdata(reg_rdata), .flash_cs_n(cs_n),
    .flash_sck(sck), .flash_mosi(mosi), .flash_miso(miso), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .strap_pin(strap_pin),
    .overlay_enable(overlay_enable), .core_osd_access(osd), .core_slow_io_access(slow),
    .core_enable(core_enable), .core_soft_reset(core_soft_reset), .core_stall(core_stall),
    .core_wait(core_wait), .cache_enable(cache_enable), .code_cache_segment(seg),
    .core_timer_source(tsrc), .core_timer_invert(tinv), .page_select(page));
  sfmb_flash sfmb_flash_i (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
  end
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  always @(posedge clk)
    if (cyc == 60000)
    begin
      err_count = err_count + 1;
      wrap_up;
    end
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] e);
  begin
    check_count = check_count + 1;
    if (seen !== e)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, seen);
    end
  end
  endtask
  // Byte the flash model returns at a given byte position of a frame.
  function [7:0] rd_exp(input [15:0] p);
    rd_exp = 8'hc0 + p[7:0];
  endfunction
  task wr(input [7:0] a, input [7:0] dv, input h);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_wdata = dv;
    reg_from_host = h;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  end
  endtask
  task rd(input [7:0] a, output [7:0] q);
  begin
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    q = reg_rdata;
  end
  endtask
  task rc(input [7:0] a, input [7:0] e);
  begin
    rd(a, rv);
    chk("reg", {a, rv}, {a, e});
  end
  endtask
  task idle(input [7:0] a, input p);
  begin
    t = 0;
    rd(a, rv);
    while (rv[7] === p && t < 5000)
    begin
      rd(a, rv);
      t = t + 1;
    end
    chk("idle", t < 5000, 1);
  end
  endtask
  // Counts wait cycles after one access pulse of the chosen kind.
  task wcount(input s, input [2:0] e);
  begin
    @(negedge clk);
    slow = s;
    osd = !s;
    n = 0;
    repeat (12)
    begin
      @(negedge clk);
      slow = 1'b0;
      osd = 1'b0;
      n = n + core_wait;
    end
    chk("wait", n, e);
  end
  endtask
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = i[7:0] ^ 8'h3c;
    repeat (16)
      @(negedge clk);
    arst_n = 1'b1;
    for (i = 9'h0e0; i < 9'h100; i = i + 1)
      if (i < 9'h0f6 || i > 9'h0f8)
        rc(i[7:0], i == 9'h0fa ? 8'h80 : i == 9'h0fe ? 8'h05 : 8'h00);
    rc(8'h3a, 8'h00);
    chk("enable", core_enable, 0);
    for (i = 0; i < 16; i = i + 1)
    begin
      mb[i] = $random(seed);
      wr({4'he, i[3:0]}, mb[i], i[0]);
    end
    for (i = 0; i < 16; i = i + 1)
      rc({4'he, i[3:0]}, mb[i]);
    wr(8'hff, 8'h83, 1'b0);
    rc(8'hff, 8'h03);
    chk("stall", core_stall, 0);
    wr(8'hff, 8'hff, 1'b1);
    rc(8'hff, 8'h83);
    chk("stall", {page, core_stall}, 7);
    wr(8'hff, 8'h00, 1'b0);
    rc(8'hff, 8'h00);
    repeat (4)
    begin
      v = $random(seed);
      wr(8'hfd, v, 1'b0);
      rc(8'hfd, v & 8'hee);
      chk("cache", {cache_enable, seg, tsrc, tinv}, {v[7], v[3:1], v[6], v[5]});
      v = $random(seed) & 8'h9f;
      wr(8'hfe, v, 1'b0);
      rc(8'hfe, v);
      chk("enable", core_enable, v[7]);
      overlay_enable = v[0];
      wcount(1'b1, {1'b0, v[1:0]});
      wcount(1'b0, v[0] ? v[4:2] : 3'h0);
    end
    wr(8'hfe, 8'h45, 1'b0);
    rc(8'hfe, 8'h05);
    op = $random(seed);
    op[7] = 1'b1;
    wr(8'hf0, op, 1'b0);
    f0 = frames;
    wr(8'hf5, 8'h84, 1'b0);
    wr(8'hf5, 8'h84, 1'b0);
    rc(8'hf5, 8'h84);
    idle(8'hf5, 1'b1);
    chk("frames", frames - f0, 1);
    chk("cmd", sfmb_flash_i.got[0], op);
    rc(8'hf6, rd_exp(16'h0001));
    wr(8'hfb, 8'h03, 1'b0);
    for (i = 0; i < 5; i = i + 1)
    begin
      wl = i + 3;
      if (i == 0)
        wl = 3'h0;
      rl = 2 - i % 3;
      nr = (rl == 2) ? 3 : rl;
      ad = $random(seed);
      d = $random(seed);
      wr(8'hf1, ad[7:0], 1'b0);
      wr(8'hf2, ad[15:8], 1'b0);
      wr(8'hf3, ad[23:16], 1'b0);
      wr(8'hf4, d, 1'b0);
      ex[0] = op;
      ex[1] = ad[23:16];
      ex[2] = ad[15:8];
      ex[3] = ad[7:0];
      m = (wl > 4) ? 4 : 1;
      for (k = 0; k < 3; k = k + 1)
        ex[m + k] = (wl == 7) ? mb[k] : d;
      m = m + (wl == 4 || wl == 6) + 3 * (wl == 7);
      wr(8'hf5, {1'b1, wl, rl, 2'b00}, 1'b0);
      idle(8'hf5, 1'b1);
      chk("bytes", fpos, (m + nr) << 3);
      for (k = 0; k < m; k = k + 1)
        chk("mosi", sfmb_flash_i.got[k], ex[k]);
      for (k = 0; k < nr; k = k + 1)
        rc(8'hf6 + k[7:0], rd_exp(m + k));
    end
    wr(8'hf5, 8'h8c, 1'b0);
    repeat (300)
      @(negedge clk);
    wr(8'hf5, 8'h0c, 1'b0);
    idle(8'hf5, 1'b1);
    chk("repeat", fpos > 16, 1);
    k = sfmb_flash_i.stat_n;
    wr(8'hf5, 8'h83, 1'b0);
    rc(8'hf5, 8'h81);
    chk("stall", core_stall, 1);
    idle(8'hf5, 1'b1);
    rc(8'hf5, 8'h03);
    chk("stall", core_stall, 0);
    chk("polls", sfmb_flash_i.stat_n - k, 3);
    rc(8'hf6, 8'h02);
    wr(8'hf5, 8'h00, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      n = 1 + ($random(seed) & 3);
      da = $random(seed);
      wr(8'hf9, da[7:0], 1'b0);
      wr(8'hfa, da[15:8], 1'b0);
      wr(8'hfb, n[7:0], 1'b0);
      f0 = frames;
      wr(8'hfc, i ? 8'h80 : 8'he0, 1'b0);
      wr(8'hfc, i ? 8'h80 : 8'he0, 1'b0);
      rc(8'hfc, i ? 8'h00 : 8'h60);
      chk("stall", core_stall, !i);
      idle(8'hfc, 1'b0);
      chk("frames", frames - f0, 1);
      chk("bytes", fpos, (n + 16'h0004) << 3);
      for (k = 0; k < n; k = k + 1)
        chk("move", i ? sfmb_flash_i.got[4 + k] : mem[da + k], i ? mem[da + k] : 8'hc4 + k[7:0]);
    end
    strap_pin = 1'b1;
    arst_n = 1'b0;
    repeat (16)
      @(negedge clk);
    arst_n = 1'b1;
    repeat (6)
      @(negedge clk);
    chk("enable", core_enable, 1);
    rc(8'hfe, 8'h85);
    wrap_up;
  end
endmodule

// >>> verif/sfmb_flash.sv
// Behavioural serial flash: logs the bytes of the last frame and answers reads.
// Assumes clock mode 0; a read byte is 0xC0 plus its position in the frame, except in a status read after opcode 05h.
`timescale 1ns/1ps
module sfmb_flash (
  input wire cs_n,
  input wire sck,
  input wire mosi,
  output reg miso
);
  reg [7:0] got [0:63];
  reg [7:0] sh;
  reg [7:0] tx;
  reg [15:0] pos;
  reg [15:0] frames;
  reg [15:0] stat_n;
  reg [15:0] wip_left;
  function [7:0] out_byte(input [15:0] n);
    if (got[0] == 8'h05 && n > 0)
      out_byte = (wip_left != 0) ? 8'h03 : 8'h02;
    else
      out_byte = 8'hc0 + n[7:0];
  endfunction
  initial
  begin
    miso = 1'b0;
    pos = 0;
    frames = 0;
    stat_n = 0;
    wip_left = 0;
  end
  always @(negedge cs_n)
  begin
    pos = 0;
    frames = frames + 1;
  end
  // A released line shows the inverse of its last value, never a held copy.
  always @(posedge cs_n)
  begin
    miso = ~miso;
    if (got[0] != 8'h05)
      wip_left = 2;
  end
  always @(posedge sck)
    if (!cs_n)
    begin
      sh = {sh[6:0], mosi};
      pos = pos + 1;
      if (pos % 8 == 0)
      begin
        got[(pos / 8 - 1) % 64] = sh;
        if (got[0] == 8'h05 && pos > 8)
        begin
          stat_n = stat_n + 1;
          if (wip_left != 0)
            wip_left = wip_left - 1;
        end
      end
    end
  always @(negedge sck)
    if (!cs_n)
    begin
      tx = out_byte(pos / 8);
      miso <= tx[7 - pos % 8];
    end
endmodule

// >>> verilog/sfmb_biu.v
// Serial flash master, block mover, code-cache and core controls, and shared mailbox.
// Assumes one clock, registers written over an 8-bit port, and a memory that answers a read the cycle after mem_rd.
`timescale 1ns/1ps
`include "sfmb_defs.vh"
module sfmb_biu #(
  parameter SCK_HALF = `SFMB_SCK_HALF_CYC,
  parameter [7:0] STATUS_OPCODE = 8'h05
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_from_host,
  output reg [7:0] reg_rdata,
  output reg flash_cs_n,
  output reg flash_sck,
  output reg flash_mosi,
  input wire flash_miso,
  output reg [15:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire strap_pin,
  input wire overlay_enable,
  input wire core_osd_access,
  input wire core_slow_io_access,
  output reg core_enable,
  output reg core_soft_reset,
  output reg core_stall,
  output reg core_wait,
  output reg cache_enable,
  output reg [2:0] code_cache_segment,
  output reg core_timer_source,
  output reg core_timer_invert,
  output reg [1:0] page_select
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LOAD = 3'd1;
  localparam ST_FETCH = 3'd2;
  localparam ST_PICK = 3'd3;
  localparam ST_SHIFT = 3'd4;
  localparam ST_GAP = 3'd5;
  localparam P_CMD = 3'd0;
  localparam P_ADR = 3'd1;
  localparam P_WDT = 3'd2;
  localparam P_WBF = 3'd3;
  localparam P_RD = 3'd4;
  localparam P_PCMD = 3'd5;
  localparam P_PRD = 3'd6;

  reg [7:0] mbox [0:15];
  reg [7:0] flash_opcode;
  reg [23:0] flash_addr;
  reg [7:0] flash_single_write_byte;
  reg [2:0] wlen;
  reg [1:0] rlen;
  reg wait_done;
  reg wip_fell;
  reg [7:0] rd0, rd1, rd2;
  reg [15:0] dma_addr;
  reg [12:0] dma_cnt;
  reg dma_dir, dma_hold, dma_done;
  reg [2:0] overlay_ram_wait;
  reg [1:0] pixel_domain_io_wait;
  reg core_freeze;
  reg [2:0] miso_s, strap_s;
  reg miso_f;
  reg [1:0] strap_cnt;
  reg strap_done;
  reg [2:0] state, ph;
  reg [12:0] idx;
  reg [15:0] dptr;
  reg [7:0] tx, rx;
  reg [2:0] bitn;
  reg [7:0] div;
  reg run_dma, run_dir, run_hold, run_poll, stop_req;
  reg [2:0] run_wlen;
  reg [1:0] run_rlen;
  reg [2:0] wcnt;
  reg [7:0] next_rdata, next_tx;
  reg [2:0] next_ph;
  reg [12:0] next_idx;
  reg fin, gap;

  wire busy = (state != ST_IDLE);
  wire wr_ctrl = reg_wr && (reg_addr == `SFMB_CTRL);
  wire wr_dctrl = reg_wr && (reg_addr == `SFMB_DCTRL);
  wire launch = wr_ctrl && reg_wdata[`SFMB_B_GO] && !busy; // R3 R23
  wire dma_go = wr_dctrl && reg_wdata[`SFMB_B_GO] && !busy; // R11 R23
  wire tick = (div == SCK_HALF[7:0] - 8'h01);
  wire [7:0] rx_full = {rx[6:0], miso_f};
  wire byte_done = (state == ST_SHIFT) && tick && flash_sck && (bitn == 3'h7);
  wire [12:0] idx_inc = idx + 13'h0001;
  wire [2:0] aw_ph = (run_rlen != 2'h0) ? P_RD : P_PCMD;
  wire aw_fin = (run_rlen == 2'h0) && !run_poll;
  wire aw_gap = (run_rlen == 2'h0) && run_poll;

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : mb
      always @(posedge clk or negedge arst_n)
        if (!arst_n)
          mbox[g] <= 8'h00;
        else if (reg_wr && reg_addr == {`SFMB_MBOX_HI, g[3:0]})
          mbox[g] <= reg_wdata; // R21
    end
  endgenerate

  always @*
  begin
    next_rdata = 8'h00;
    if (reg_addr[7:4] == `SFMB_MBOX_HI)
      next_rdata = mbox[reg_addr[3:0]];
    else
      case (reg_addr)
        `SFMB_OPCODE: next_rdata = flash_opcode;
        `SFMB_ADDR0: next_rdata = flash_addr[7:0];
        `SFMB_ADDR1: next_rdata = flash_addr[15:8];
        `SFMB_ADDR2: next_rdata = flash_addr[23:16];
        `SFMB_WBYTE: next_rdata = flash_single_write_byte;
        `SFMB_CTRL: next_rdata = {busy, wlen, rlen, wip_fell, wait_done}; // R3 R6
        `SFMB_RD0: next_rdata = rd0;
        `SFMB_RD1: next_rdata = rd1;
        `SFMB_RD2: next_rdata = rd2;
        `SFMB_DADR_LO: next_rdata = dma_addr[7:0];
        `SFMB_DADR_HI: next_rdata = dma_addr[15:8];
        `SFMB_DCNT_LO: next_rdata = dma_cnt[7:0];
        `SFMB_DCTRL: next_rdata = {dma_done, dma_dir, dma_hold, dma_cnt[12:8]}; // R11
        `SFMB_CACHE: next_rdata = {cache_enable, core_timer_source, core_timer_invert, 1'b0, code_cache_segment, 1'b0};
        `SFMB_BIUCTL: next_rdata = {core_enable, 2'b00, overlay_ram_wait, pixel_domain_io_wait};
        `SFMB_PAGE: next_rdata = {core_freeze, 5'h00, page_select};
        default: next_rdata = 8'h00;
      endcase
  end

  // Source of the byte about to be shifted out.
  always @*
  begin
    next_tx = 8'h00;
    case (ph)
      P_CMD: next_tx = flash_opcode; // R1
      P_ADR: next_tx = (idx == 13'h0000) ? flash_addr[23:16] : (idx == 13'h0001) ? flash_addr[15:8] : flash_addr[7:0]; // R2
      P_WDT: next_tx = flash_single_write_byte;
      P_WBF: next_tx = run_dma ? mem_rdata : mbox[idx[3:0]];
      P_PCMD: next_tx = STATUS_OPCODE; // R6
      default: next_tx = 8'h00;
    endcase
  end

  // Phase that follows the byte just finished.
  always @*
  begin
    next_ph = ph;
    next_idx = 13'h0000;
    fin = 1'b0;
    gap = 1'b0;
    case (ph)
      P_CMD:
      begin
        if (run_dma || run_wlen == `SFMB_WL_ADDR || run_wlen[2:1] == 2'b11)
          next_ph = P_ADR; // R4
        else if (run_wlen == `SFMB_WL_ONE)
          next_ph = P_WDT;
        else
        begin
          next_ph = aw_ph;
          fin = aw_fin;
          gap = aw_gap;
        end
      end
      P_ADR:
      begin
        if (idx != 13'h0002)
          next_idx = idx_inc;
        else if (run_dma)
        begin
          fin = (dma_cnt == 13'h0000);
          next_ph = run_dir ? P_RD : P_WBF; // R12
        end
        else if (run_wlen == `SFMB_WL_ADDR_DATA)
          next_ph = P_WDT;
        else if (run_wlen[1:0] == 2'b11 && dma_cnt != 13'h0000)
          next_ph = P_WBF;
        else
        begin
          next_ph = aw_ph;
          fin = aw_fin;
          gap = aw_gap;
        end
      end
      P_WDT:
      begin
        next_ph = aw_ph;
        fin = aw_fin;
        gap = aw_gap;
      end
      P_WBF:
      begin
        if (idx_inc != dma_cnt)
          next_idx = idx_inc; // R10
        else if (run_dma)
          fin = 1'b1;
        else
        begin
          next_ph = aw_ph;
          fin = aw_fin;
          gap = aw_gap;
        end
      end
      P_RD:
      begin
        if (run_dma)
        begin
          next_idx = idx_inc;
          fin = (idx_inc == dma_cnt); // R10
        end
        else if (run_rlen == `SFMB_RL_REPEAT && !stop_req)
          next_idx = idx;
        else if (run_rlen == `SFMB_RL_REPEAT || idx == ((run_rlen == `SFMB_RL_ONE) ? 13'h0000 : 13'h0002))
        begin
          next_ph = P_PCMD; // R5
          fin = !run_poll;
          gap = run_poll;
        end
        else
          next_idx = idx_inc;
      end
      P_PCMD: next_ph = P_PRD;
      P_PRD: fin = !rx_full[0]; // R6
      default: fin = 1'b1;
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      miso_s <= 3'h0;
      miso_f <= 1'b0;
      strap_s <= 3'h0;
      reg_rdata <= 8'h00;
      flash_opcode <= 8'h00;
      flash_addr <= 24'h000000;
      flash_single_write_byte <= 8'h00;
      wlen <= 3'h0;
      rlen <= 2'h0;
      wait_done <= 1'b0;
      wip_fell <= 1'b0;
      rd0 <= 8'h00;
      rd1 <= 8'h00;
      rd2 <= 8'h00;
      dma_addr <= {`SFMB_DADR_HI_RST, 8'h00};
      dma_cnt <= 13'h0000;
      dma_dir <= 1'b0;
      dma_hold <= 1'b0;
      dma_done <= 1'b0;
      cache_enable <= 1'b0;
      core_timer_source <= 1'b0;
      core_timer_invert <= 1'b0;
      code_cache_segment <= 3'h0;
      core_enable <= 1'b0;
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      core_soft_reset <= 1'b0;
      {overlay_ram_wait, pixel_domain_io_wait} <= `SFMB_BIUCTL_RST;
      core_freeze <= 1'b0;
      page_select <= 2'h0;
      core_stall <= 1'b0;
      core_wait <= 1'b0;
      wcnt <= 3'h0;
    end
    else
    begin
      miso_s <= {miso_s[1:0], flash_miso};
      if (miso_s[1] == miso_s[2])
        miso_f <= miso_s[2];
      strap_s <= {strap_s[1:0], strap_pin};
      reg_rdata <= next_rdata;
      if (reg_wr)
        case (reg_addr)
          `SFMB_OPCODE: flash_opcode <= reg_wdata; // R1
          `SFMB_ADDR0: flash_addr[7:0] <= reg_wdata; // R2
          `SFMB_ADDR1: flash_addr[15:8] <= reg_wdata;
          `SFMB_ADDR2: flash_addr[23:16] <= reg_wdata;
          `SFMB_WBYTE: flash_single_write_byte <= reg_wdata;
          `SFMB_CTRL: {wlen, rlen, wait_done} <= {reg_wdata[6:2], reg_wdata[`SFMB_B_WAITD]}; // R4 R5 R7
          `SFMB_DADR_LO: dma_addr[7:0] <= reg_wdata; // R9
          `SFMB_DADR_HI: dma_addr[15:8] <= reg_wdata;
          `SFMB_DCNT_LO: dma_cnt[7:0] <= reg_wdata;
          `SFMB_DCTRL: {dma_dir, dma_hold, dma_cnt[12:8]} <= reg_wdata[6:0]; // R10 R12 R13
          `SFMB_CACHE: {cache_enable, core_timer_source, core_timer_invert, code_cache_segment}
            <= {reg_wdata[7:5], reg_wdata[3:1]}; // R14 R15
          `SFMB_BIUCTL: {overlay_ram_wait, pixel_domain_io_wait} <= reg_wdata[4:0]; // R18 R19
          `SFMB_PAGE: page_select <= reg_wdata[1:0];
          default: ;
        endcase
      if (reg_wr && reg_addr == `SFMB_PAGE && (reg_from_host || !reg_wdata[7]))
        core_freeze <= reg_wdata[7]; // R20
      core_soft_reset <= reg_wr && reg_addr == `SFMB_BIUCTL && reg_wdata[`SFMB_B_RESET]; // R17
      if (!strap_done)
      begin
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == 2'h3 && strap_s[1] == strap_s[2])
        begin
          core_enable <= strap_s[2]; // R16
          strap_done <= 1'b1;
        end
      end
      else if (reg_wr && reg_addr == `SFMB_BIUCTL)
        core_enable <= reg_wdata[7];
      // Set by the poll ending wins over the clear by a new launch.
      if (byte_done && fin && run_poll && ph == P_PRD)
        wip_fell <= 1'b1;
      else if (launch && reg_wdata[`SFMB_B_POLL])
        wip_fell <= 1'b0;
      if (byte_done && fin && run_dma)
        dma_done <= 1'b1; // R11
      else if (dma_go)
        dma_done <= 1'b0;
      if (byte_done && ph == P_RD && !run_dma)
        case (idx[1:0])
          2'h0: rd0 <= rx_full; // R8
          2'h1: rd1 <= rx_full;
          default: rd2 <= rx_full;
        endcase
      else if (byte_done && ph == P_PRD)
        rd0 <= rx_full;
      core_stall <= core_freeze || (busy && !run_dma && wait_done) || (busy && run_dma && run_hold); // R7 R13 R20
      if (core_osd_access && overlay_enable)
      begin
        wcnt <= overlay_ram_wait; // R18
        core_wait <= (overlay_ram_wait != 3'h0);
      end
      else if (core_slow_io_access)
      begin
        wcnt <= {1'b0, pixel_domain_io_wait}; // R19
        core_wait <= (pixel_domain_io_wait != 2'h0);
      end
      else if (wcnt != 3'h0)
      begin
        wcnt <= wcnt - 3'h1;
        core_wait <= (wcnt > 3'h1);
      end
    end
  end

  // Serial engine: chip select stays low from the command byte to the last byte, apart from one high gap before a status poll.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      ph <= P_CMD;
      idx <= 13'h0000;
      dptr <= 16'h0000;
      tx <= 8'h00;
      rx <= 8'h00;
      bitn <= 3'h0;
      div <= 8'h00;
      run_dma <= 1'b0;
      run_dir <= 1'b0;
      run_hold <= 1'b0;
      run_poll <= 1'b0;
      run_wlen <= 3'h0;
      run_rlen <= 2'h0;
      stop_req <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_sck <= 1'b0;
      flash_mosi <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
    end
    else
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      if (wr_ctrl && !reg_wdata[`SFMB_B_GO] && busy)
        stop_req <= 1'b1; // R5
      case (state)
        ST_IDLE:
          if (launch || dma_go)
          begin
            run_dma <= dma_go;
            run_dir <= reg_wdata[`SFMB_B_DIR];
            run_hold <= reg_wdata[`SFMB_B_HOLD];
            run_poll <= launch && reg_wdata[`SFMB_B_POLL]; // R6
            run_wlen <= reg_wdata[6:4];
            run_rlen <= reg_wdata[3:2];
            stop_req <= 1'b0;
            dptr <= dma_addr; // R9
            ph <= P_CMD;
            idx <= 13'h0000;
            state <= ST_LOAD;
          end
        ST_LOAD:
        begin
          if (ph == P_WBF && run_dma)
          begin
            mem_rd <= 1'b1;
            mem_addr <= dptr;
            dptr <= dptr + 16'h0001;
          end
          state <= ST_FETCH;
        end
        ST_FETCH: state <= ST_PICK;
        ST_PICK:
        begin
          tx <= next_tx;
          flash_mosi <= next_tx[7]; // R22
          flash_cs_n <= 1'b0;
          div <= 8'h00;
          bitn <= 3'h0;
          state <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          div <= tick ? 8'h00 : div + 8'h01;
          if (tick && !flash_sck)
            flash_sck <= 1'b1;
          else if (tick)
          begin
            flash_sck <= 1'b0;
            rx <= rx_full;
            tx <= {tx[6:0], 1'b0};
            flash_mosi <= tx[6]; // R22
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7)
            begin
              if (ph == P_RD && run_dma)
              begin
                mem_wr <= 1'b1; // R12
                mem_wdata <= rx_full;
                mem_addr <= dptr;
                dptr <= dptr + 16'h0001;
              end
              ph <= next_ph;
              idx <= next_idx;
              if (fin || gap)
                flash_cs_n <= 1'b1;
              state <= fin ? ST_IDLE : gap ? ST_GAP : ST_LOAD;
            end
          end
        end
        ST_GAP:
        begin
          div <= div + 8'h01;
          if (div == {SCK_HALF[6:0], 1'b0})
            state <= ST_LOAD;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> verilog/sfmb_defs.vh
// Register offsets, field positions, reset values and timing of the flash bus-interface block.
// Assumes an 8-bit register port addressed by the core and by the two-wire host.
// What this block does
// R1: Opcode register sent as command byte.
// R2: Three address bytes, sent highest first.
// R3: Launch bit starts cycle; reads busy.
// R4: Write-length field selects write phase bytes.
// R5: Read-length field selects read byte count.
// R6: Poll bit repeats status read until clear.
// R7: Wait-done bit stalls core during cycle.
// R8: First three read bytes land in captures.
// R9: Block-move address 16 bits, resets 8000h.
// R10: Block-move count is 13-bit byte count.
// R11: Go bit starts move; reads finished.
// R12: Direction bit: 0 to flash, 1 to chip.
// R13: Hold bit stalls core during move.
// R14: Cache enable and 8KB segment select.
// R15: Timer clock source select and invert.
// R16: Core enable resets from sampled strap.
// R17: Writing one resets core; write-only.
// R18: Overlay RAM wait states when overlay enabled.
// R19: Pixel-domain I/O wait states, two bits.
// R20: Freeze bit set only by host.
// R21: Sixteen shared mailbox bytes.
// R22: Chip select held whole cycle except one gap before status polling, MSB first.
// R23: Start requests ignored while busy.
`ifndef SFMB_DEFS_VH
`define SFMB_DEFS_VH
`define SFMB_MBOX_HI 4'he
`define SFMB_OPCODE 8'hf0
`define SFMB_ADDR0 8'hf1
`define SFMB_ADDR1 8'hf2
`define SFMB_ADDR2 8'hf3
`define SFMB_WBYTE 8'hf4
`define SFMB_CTRL 8'hf5
`define SFMB_RD0 8'hf6
`define SFMB_RD1 8'hf7
`define SFMB_RD2 8'hf8
`define SFMB_DADR_LO 8'hf9
`define SFMB_DADR_HI 8'hfa
`define SFMB_DCNT_LO 8'hfb
`define SFMB_DCTRL 8'hfc
`define SFMB_CACHE 8'hfd
`define SFMB_BIUCTL 8'hfe
`define SFMB_PAGE 8'hff
`define SFMB_B_GO 7
`define SFMB_B_DIR 6
`define SFMB_B_HOLD 5
`define SFMB_B_POLL 1
`define SFMB_B_WAITD 0
`define SFMB_B_RESET 6
`define SFMB_DADR_HI_RST 8'h80
`define SFMB_BIUCTL_RST 5'h05
`define SFMB_WL_ONE 3'h4
`define SFMB_WL_ADDR 3'h5
`define SFMB_WL_ADDR_DATA 3'h6
`define SFMB_RL_ONE 2'h1
`define SFMB_RL_REPEAT 2'h3
`define SFMB_CLK_NS 10
`define SFMB_SCK_HALF_NS 40
`define SFMB_SCK_HALF_CYC ((`SFMB_SCK_HALF_NS + `SFMB_CLK_NS - 1) / `SFMB_CLK_NS)
`endif
